//--- verilog/sfr_map.svh
// register offsets, field positions, reset values and timing counts
// Behaviour
// - fade-out code in bits 7:4, 0 disables
// - fade-in code in bits 3:0, same encoding
// - fade-out time means full 30 mA ramp
// - fade-in time means full 30 mA ramp
// - partial fades keep full-scale rate, finish sooner
// - fade register sits at address 0x13
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// ****************************************************************
// register map
// ****************************************************************
`define SFR_ADDR_W          8
`define SFR_DATA_W          8
`define SFR_FADE_ADDR       8'h13
`define SFR_FADE_RESET      8'h00
`define SFR_RDATA_IDLE      8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define SFR_OUT_MSB         7
`define SFR_OUT_LSB         4
`define SFR_IN_MSB          3
`define SFR_IN_LSB          0
`define SFR_CODE_W          4
`define SFR_CODE_OFF        4'h0

// ****************************************************************
// current level scale
// ****************************************************************
`define SFR_LEVEL_W         7
`define SFR_LEVEL_ZERO      7'h00
`define SFR_FULL_CODES      127
`define SFR_FULL_MA         30

// ****************************************************************
// timing: durations counted in tenths of a second
// ****************************************************************
`define SFR_CLK_PERIOD_NS   100
`define SFR_TENTH_MS        100
`define SFR_TENTH_CYC       ((`SFR_TENTH_MS * 1000000) / `SFR_CLK_PERIOD_NS)
`define SFR_STEP_CYC        (`SFR_TENTH_CYC / `SFR_FULL_CODES)
`define SFR_UNITS_W         6
`define SFR_CNT_W           24

`endif

//--- verilog/sfr_pkg.sv
// types shared by the sink fade-rate block
`default_nettype none
package sfr_pkg;

    // ************************************************************
    // ramp engine states
    // ************************************************************
    typedef enum logic [1:0] {
        SFR_IDLE    = 2'b00,
        SFR_RAMP_UP = 2'b01,
        SFR_RAMP_DN = 2'b10
    } sfr_state_t;

    // a four-bit fade duration code
    typedef logic [3:0] sfr_code_t;

endpackage
`default_nettype wire

//--- verilog/sfr_top.sv
// sink fade-rate register and full-scale-rate current ramp engine
`timescale 1ns/1ps
`default_nettype none
`include "sfr_map.svh"

module sfr_top #(
    // clock cycles of one step when the duration is one tenth second
    parameter int unsigned TENTH_STEP_CYC = `SFR_STEP_CYC
) (
    // clock and reset
    input  wire logic                     clk_sys_in,
    input  wire logic                     sys_rst_in,
    // register port from the serial programming logic
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    input  wire logic [`SFR_ADDR_W-1:0]   reg_addr_in,
    input  wire logic [`SFR_DATA_W-1:0]   reg_wdata_in,
    output var  logic [`SFR_DATA_W-1:0]   reg_rdata_out,
    // fade codes towards the sink drivers
    output var  logic [`SFR_CODE_W-1:0]   fade_out_code_out,
    output var  logic [`SFR_CODE_W-1:0]   fade_in_code_out,
    // current level request and ramped result
    input  wire logic [`SFR_LEVEL_W-1:0]  target_in,
    output var  logic [`SFR_LEVEL_W-1:0]  level_out,
    output var  logic                     busy_out
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the step counter must hold the longest step period
    localparam longint unsigned MAX_PERIOD =
        longint'(TENTH_STEP_CYC) * 55;

    generate
        if (TENTH_STEP_CYC < 1) begin : g_bad_step
            $error("step period must be at least one cycle");
        end
        if (MAX_PERIOD >= (64'h0000_0001 << `SFR_CNT_W)) begin : g_bad_w
            $error("step period too long for the step counter");
        end
    endgenerate

    // ************************************************************
    // decoding functions
    // ************************************************************
    // duration in tenths of a second for a nonzero code:
    // 1..10 step by three tenths, 11..15 by five tenths from 35
    function automatic logic [`SFR_UNITS_W-1:0] code_units(
        input sfr_pkg::sfr_code_t code
    );
        logic [`SFR_UNITS_W-1:0] c;
        c = {2'b00, code};
        if (code <= 4'hA) begin
            code_units = c * 6'h03;
        end else begin
            code_units = 6'h23 + (c - 6'h0B) * 6'h05;
        end
    endfunction

    // cycles between two one-code steps of the level; the full
    // scale of 127 codes then takes the whole selected duration
    function automatic logic [`SFR_CNT_W-1:0] step_period(
        input sfr_pkg::sfr_code_t code
    );
        logic [`SFR_CNT_W-1:0] u;
        logic [`SFR_CNT_W-1:0] s;
        u = {{(`SFR_CNT_W-`SFR_UNITS_W){1'b0}}, code_units(code)};
        s = TENTH_STEP_CYC[`SFR_CNT_W-1:0];
        step_period = u * s;
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    logic [`SFR_DATA_W-1:0]   fade_rates_ff;  // sink_fade_rates
    logic [`SFR_DATA_W-1:0]   nxt_fade_rates;
    logic [`SFR_DATA_W-1:0]   rdata_ff;       // read answer
    logic [`SFR_DATA_W-1:0]   nxt_rdata;
    logic [`SFR_LEVEL_W-1:0]  level_ff;       // present level
    logic [`SFR_LEVEL_W-1:0]  nxt_level;
    logic [`SFR_CNT_W-1:0]    cnt_ff;         // step timer
    logic [`SFR_CNT_W-1:0]    nxt_cnt;
    sfr_pkg::sfr_state_t      state_ff;       // ramp state
    sfr_pkg::sfr_state_t      nxt_state;
    logic                     busy_ff;        // ramp in progress
    logic                     nxt_busy;

    // ************************************************************
    // register decode
    // ************************************************************
    // the fade register answers at its own address only
    // address decode
    wire hit_fade = (reg_addr_in == `SFR_FADE_ADDR);
    wire wr_fade  = reg_wr_in & hit_fade;
    wire rd_fade  = reg_rd_in & hit_fade;

    // fields of the stored register
    // fade-out field
    wire sfr_pkg::sfr_code_t out_code =
        fade_rates_ff[`SFR_OUT_MSB:`SFR_OUT_LSB];
    wire sfr_pkg::sfr_code_t in_code =
        fade_rates_ff[`SFR_IN_MSB:`SFR_IN_LSB];

    // a write replaces the whole byte; both fields are live at once
    assign nxt_fade_rates = wr_fade ? reg_wdata_in : fade_rates_ff;

    // other addresses read as zero so the outer mux can or them
    assign nxt_rdata = rd_fade ? fade_rates_ff : `SFR_RDATA_IDLE;

    // ************************************************************
    // ramp decisions
    // ************************************************************
    wire go_up   = (target_in > level_ff);   // target above level
    wire go_dn   = (target_in < level_ff);   // target below level
    wire at_tgt  = ~go_up & ~go_dn;          // nothing to do

    // the code that governs the ramp depends on its direction
    wire sfr_pkg::sfr_code_t dir_code = go_up ? in_code : out_code;

    wire no_fade = (dir_code == `SFR_CODE_OFF);

    wire [`SFR_CNT_W-1:0] period = step_period(dir_code);

    // a step falls due when the timer reaches one less than the period; codes
    // written mid-ramp take effect on the next comparison
    wire step_due = (cnt_ff >= period - 24'h00_0001);

    // one-code moves in either direction
    wire [`SFR_LEVEL_W-1:0] level_up = level_ff + 7'h01;
    wire [`SFR_LEVEL_W-1:0] level_dn = level_ff - 7'h01;

    // ************************************************************
    // ramp state machine
    // ************************************************************
    // the rate per code is fixed by the selected duration, so a
    // partial fade simply ends early; the trade is that a fade is
    // never stretched to fill the chosen time
    always_comb begin
        nxt_state = state_ff;
        nxt_level = level_ff;
        nxt_cnt   = cnt_ff;
        nxt_busy  = busy_ff;
        case (state_ff)
            // waiting for the target to move
            sfr_pkg::SFR_IDLE: begin
                nxt_cnt  = {`SFR_CNT_W{1'b0}};
                nxt_busy = 1'b0;
                if (!at_tgt) begin
                    if (no_fade) begin
                        nxt_level = target_in;
                    end else begin
                        nxt_busy  = 1'b1;
                        nxt_state = go_up ? sfr_pkg::SFR_RAMP_UP
                                          : sfr_pkg::SFR_RAMP_DN;
                    end
                end
            end
            // rising towards the target
            sfr_pkg::SFR_RAMP_UP: begin
                if (!go_up || no_fade) begin
                    // target reached, reversed or fade disabled
                    nxt_state = sfr_pkg::SFR_IDLE;
                    nxt_cnt   = {`SFR_CNT_W{1'b0}};
                end else if (step_due) begin
                    nxt_level = level_up;
                    nxt_cnt   = {`SFR_CNT_W{1'b0}};
                    if (level_up == target_in) begin
                        nxt_state = sfr_pkg::SFR_IDLE;
                        nxt_busy  = 1'b0;
                    end
                end else begin
                    nxt_cnt = cnt_ff + 24'h00_0001;
                end
            end
            // falling towards the target
            sfr_pkg::SFR_RAMP_DN: begin
                if (!go_dn || no_fade) begin
                    nxt_state = sfr_pkg::SFR_IDLE;
                    nxt_cnt   = {`SFR_CNT_W{1'b0}};
                end else if (step_due) begin
                    nxt_level = level_dn;
                    nxt_cnt   = {`SFR_CNT_W{1'b0}};
                    if (level_dn == target_in) begin
                        nxt_state = sfr_pkg::SFR_IDLE;
                        nxt_busy  = 1'b0;
                    end
                end else begin
                    nxt_cnt = cnt_ff + 24'h00_0001;
                end
            end
            // unreachable codes fall back to idle
            default: begin
                nxt_state = sfr_pkg::SFR_IDLE;
                nxt_cnt   = {`SFR_CNT_W{1'b0}};
                nxt_busy  = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // register file flops
    // ************************************************************
    // fade codes reset to disabled so the sinks start unramped
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            fade_rates_ff <= `SFR_FADE_RESET;
            rdata_ff      <= `SFR_RDATA_IDLE;
        end else begin
            fade_rates_ff <= nxt_fade_rates;
            rdata_ff      <= nxt_rdata;
        end
    end

    // ************************************************************
    // ramp flops
    // ************************************************************
    // level starts at zero current after reset
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_ff <= sfr_pkg::SFR_IDLE;
            level_ff <= `SFR_LEVEL_ZERO;
            cnt_ff   <= {`SFR_CNT_W{1'b0}};
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            level_ff <= nxt_level;
            cnt_ff   <= nxt_cnt;
            busy_ff  <= nxt_busy;
        end
    end

    // ************************************************************
    // outputs, all straight from flops
    // ************************************************************
    assign reg_rdata_out     = rdata_ff;
    assign fade_out_code_out = fade_rates_ff[`SFR_OUT_MSB:`SFR_OUT_LSB];
    assign fade_in_code_out  = fade_rates_ff[`SFR_IN_MSB:`SFR_IN_LSB];
    assign level_out         = level_ff;
    assign busy_out          = busy_ff;

endmodule
`default_nettype wire

//--- testbench/sfr_top_asserts.sv
// checker for the sink fade-rate register and ramp engine
`timescale 1ns/1ps
`default_nettype none
`include "sfr_map.svh"
module sfr_top_asserts #(
    parameter int unsigned TENTH_STEP_CYC = 1
) (
    // watched ports
    input wire logic                    clk_sys_in,
    input wire logic                    sys_rst_in,
    input wire logic                    reg_wr_in,
    input wire logic                    reg_rd_in,
    input wire logic [`SFR_ADDR_W-1:0]  reg_addr_in,
    input wire logic [`SFR_DATA_W-1:0]  reg_wdata_in,
    input wire logic [`SFR_DATA_W-1:0]  reg_rdata_out,
    input wire logic [`SFR_CODE_W-1:0]  fade_out_code_out,
    input wire logic [`SFR_CODE_W-1:0]  fade_in_code_out,
    input wire logic [`SFR_LEVEL_W-1:0] target_in,
    input wire logic [`SFR_LEVEL_W-1:0] level_out,
    input wire logic                    busy_out
);
    // ************************************************************
    // helper logic
    // ************************************************************
    // wide enough for the longest step at the default step period
    logic [`SFR_CNT_W-1:0] cnt_ff;                // cycles since last move
    logic        seen_ff;                         // a timed step seen
    wire logic   hit_w = reg_addr_in == `SFR_FADE_ADDR; // fade address
    // tenths per code; zero means no fade
    function automatic int units(input logic [3:0] c);
        return (c == 4'h0) ? 0 : (c <= 4'hA) ? 3 * c : 35 + 5 * (c - 11);
    endfunction
    // seen clears on any write or target move, as spacing restarts then
    always_ff @(posedge clk_sys_in) begin
        cnt_ff  <= $changed(level_out) ? 24'h00_0001 : cnt_ff + 24'h00_0001;
        seen_ff <= !sys_rst_in && busy_out && !reg_wr_in
                   && !$changed(target_in) && (seen_ff || $changed(level_out));
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    AST_OUT_FIELD: assert property (
        reg_wr_in && hit_w |=> fade_out_code_out == $past(reg_wdata_in[7:4]))
        else $error("fade-out code not taken from bits 7:4");
    AST_IN_FIELD: assert property (
        reg_wr_in && hit_w |=> fade_in_code_out == $past(reg_wdata_in[3:0]))
        else $error("fade-in code not taken from bits 3:0");
    AST_RD_DATA: assert property (
        reg_rd_in && hit_w |=> reg_rdata_out
            == {$past(fade_out_code_out), $past(fade_in_code_out)})
        else $error("fade register read wrong");
    AST_RD_IDLE: assert property (
        !(reg_rd_in && hit_w) |=> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    AST_JUMP_UP: assert property (
        !busy_out && target_in > level_out && fade_in_code_out == 4'h0
        |=> level_out == $past(target_in))
        else $error("disabled fade-in did not jump");
    AST_JUMP_DN: assert property (
        !busy_out && target_in < level_out && fade_out_code_out == 4'h0
        |=> level_out == $past(target_in))
        else $error("disabled fade-out did not jump");
    AST_ONE_STEP: assert property (
        busy_out ##1 busy_out |-> level_out == $past(level_out)
        || level_out == $past(level_out) + 7'h01
        || level_out + 7'h01 == $past(level_out))
        else $error("ramp moved more than one code");
    AST_STEP_GAP: assert property (
        $changed(level_out) && $past(busy_out) && seen_ff |-> cnt_ff
        == units(level_out > $past(level_out) ? fade_in_code_out
        : fade_out_code_out) * TENTH_STEP_CYC)
        else $error("ramp step spacing wrong");
endmodule
bind sfr_top sfr_top_asserts #(.TENTH_STEP_CYC(TENTH_STEP_CYC)) i_sfr_chk (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .fade_out_code_out(fade_out_code_out), .fade_in_code_out(fade_in_code_out),
    .target_in(target_in), .level_out(level_out), .busy_out(busy_out));
`default_nettype wire

//--- testbench/sfr_top_tb_top.sv
// self-checking bench for the sink fade-rate block
`timescale 1ns/1ps
`default_nettype none
module sfr_top_tb_top;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, busy;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, a;
    logic [3:0]  oc, ic;
    logic [6:0]  target = 7'h00, level, lvl = 7'h00;
    logic [31:0] seed = 32'h17580db1;             // fixed for repeat runs
    int          error_cnt = 0, samples_checked = 0;
    always #50 clk = ~clk;
    // one step per tenth keeps full-scale fades within a few thousand cycles
    sfr_top #(.TENTH_STEP_CYC(1)) i_sfr_top (.clk_sys_in(clk),
        .sys_rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .fade_out_code_out(oc),
        .fade_in_code_out(ic), .target_in(target), .level_out(level),
        .busy_out(busy));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int units(input logic [3:0] c);
        return (c == 4'h0) ? 0 : (c <= 4'hA) ? 3 * c : 35 + 5 * (c - 11);
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= ad;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(16'(rdata), 16'(exp));
    endtask
    // cycles to target: one per code moved times the step period, plus one if the target moves
    task automatic ramp(input logic [3:0] fo, input logic [3:0] fi,
                        input logic [6:0] t);
        int exp;
        int n;
        wreg(8'h13, {fo, fi});
        exp = ((t > lvl) ? t - lvl : lvl - t) * units(t > lvl ? fi : fo);
        exp = exp + 32'(t != lvl);
        @(posedge clk);
        target <= t;
        n = 0;
        while (n < 8000 && level !== t) begin
            @(posedge clk);
            n++;
            #1;
        end
        chk(16'(n), 16'(exp));
        chk(16'(level), 16'(t));
        chk(16'(busy), 16'h0000);
        lvl = t;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 chk({oc, ic, 1'b0, level}, 16'h0000);
        for (int c = 0; c < 16; c++) begin
            wreg(8'h13, {c[3:0], ~c[3:0]});
            #1 chk({8'h00, oc, ic}, {8'h00, c[3:0], ~c[3:0]});
            rreg(8'h13, {c[3:0], ~c[3:0]});
        end
        // neighbours and random holes must neither store nor answer
        for (int k = 0; k < 4; k++) begin
            a = (k == 0) ? 8'h12 : (k == 1) ? 8'h14 : 8'(rnd()) | 8'h20;
            wreg(a, 8'(rnd()));
            rreg(a, 8'h00);
            rreg(8'h13, 8'hF0);
        end
        ramp(4'h0, 4'h1, 7'h02);
        ramp(4'hA, 4'h0, 7'h7F);
        ramp(4'hB, 4'h0, 7'h00);
        ramp(4'h0, 4'hF, 7'h7F);
        ramp(4'h0, 4'h3, 7'h10);
        for (int k = 0; k < 6; k++) begin
            ramp(4'(rnd()), 4'(rnd()), 7'(rnd()));
        end
        // a fade cut short by disabling its code jumps to the target
        ramp(4'h0, 4'h0, 7'h00);
        wreg(8'h13, 8'h05);
        @(posedge clk);
        target <= 7'h7F;
        repeat (40) @(posedge clk);
        #1 chk(16'({busy, level}), 16'h0082);
        wreg(8'h13, 8'h00);
        @(posedge clk);
        #1 chk(16'({busy, level}), 16'h0082);
        @(posedge clk);
        #1 chk(16'({busy, level}), 16'h007F);
        // a reset in mid-fade returns every output to its idle value
        wreg(8'h13, 8'h20);
        @(posedge clk);
        target <= 7'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b1;
        #1 chk(16'({busy, level}), 16'h00FC);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk({rdata, oc, ic}, 16'h0000);
        chk(16'({busy, level}), 16'h0000);
        lvl = 7'h00;
        // a read in the cycle of a write still returns the old byte
        wreg(8'h13, 8'h3C);
        @(posedge clk);
        wr <= 1'b1;
        rd <= 1'b1;
        wdata <= 8'hA5;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 chk({rdata, oc, ic}, 16'h3CA5);
        rreg(8'h13, 8'hA5);
        results();
    end
    // watchdog well beyond the longest expected run
    initial begin
        #(80000 * 100);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
